// ===== logic/irq_pkg.sv
// Purpose: shared constants and carriers for the interrupt request arbiter
// Assumes: one 25 MHz clock, requests synchronous to it
// Notes: source line numbering is fixed by the gather concatenation
package irq_pkg;

  localparam int NUM_LINES = 32;
  localparam int NUM_GROUPS = 6;
  localparam int GROUP_WIDTH = 6;
  localparam int PAD_WIDTH = 36;
  localparam int NUM_ARB = 7;
  localparam int TOP_ARB = 6;
  localparam int SEL_WIDTH = 2;
  localparam int OFFSET_WIDTH = 5;

  // layout of the priority load word
  localparam int PRIO_ROT_LSB = 0;
  localparam int PRIO_SEL_LSB = 7;

  // reset values; everything masked until software opens it
  localparam logic [31:0] MASK_RESET = 32'hffff_ffff;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] PEND_RESET = 32'h0000_0000;
  localparam logic [6:0] ROT_RESET = 7'h00;
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam logic [4:0] OFFSET_RESET = 5'h00;

  // arbiter input numbers: fixed first and last, rotating range bounds
  localparam logic [2:0] REQ_FIRST = 3'h0;
  localparam logic [2:0] REQ_LAST = 3'h5;
  localparam logic [2:0] REQ_ROT_LO = 3'h1;
  localparam logic [2:0] REQ_ROT_HI = 3'h4;

  // raw requests before they are merged onto source lines
  typedef struct packed {
    logic [1:0] adc_touch;
    logic rtc_alarm;
    logic spi1;
    logic [2:0][2:0] serial_port_request;
    logic i2c;
    logic usb_host;
    logic usb_dev;
    logic nand_ctl;
    logic spi0;
    logic sd_card;
    logic [3:0] dma;
    logic [1:0] lcd;
    logic [4:0] timer;
    logic [1:0] wdt_audio;
    logic rtc_tick;
    logic battery_fault;
    logic [1:0] camera;
    logic [23:0] external_pin_request;
  } raw_request_s;

  // software write port: strobes plus one data word
  typedef struct packed {
    logic clear_source;
    logic clear_winner;
    logic load_mask;
    logic load_mode;
    logic load_priority;
    logic [31:0] data;
  } sw_write_s;

endpackage

// ===== logic/rotating_arbiter.sv
// Purpose: one six-input arbiter with rotating middle priority
// Assumes: purely combinational, used at both arbitration levels
// Notes: input 0 always first, input 5 always last
`timescale 1ns/1ps
module rotating_arbiter
(
  // requests and order select
  input wire logic [5:0] req,
  input wire logic [1:0] sel,
  // result
  output logic valid,
  output logic [2:0] grant
);

  always_comb
  begin
    logic [2:0] cand;
    cand = irq_pkg::REQ_FIRST;
    valid = |req;
    grant = irq_pkg::REQ_LAST; // R17
    // walk from highest to lowest so the last hit wins
    for (int k = 3; k >= 0; k--)
    begin
      cand = {1'b0, 2'(sel + 2'(k))} + irq_pkg::REQ_ROT_LO; // R17
      if (req[cand])
      begin
        grant = cand;
      end
    end
    if (req[0])
    begin
      grant = irq_pkg::REQ_FIRST; // R17
    end
  end

endmodule // rotating_arbiter

// ===== logic/source_gather.sv
// Purpose: merge raw peripheral and pin requests onto 32 source lines
// Assumes: raw requests are active-high levels or pulses
// Notes: no per-sub-request masking in this block
`timescale 1ns/1ps
module source_gather
(
  // raw requests
  input wire irq_pkg::raw_request_s raw,
  // merged lines
  output logic [31:0] lines
);

  wire [23:0] pins;
  assign pins = raw.external_pin_request;

  // sixty inputs collapse to thirty-two lines, shared ones by OR
  assign lines = {
    |raw.adc_touch,                   // 31
    raw.rtc_alarm,
    raw.spi1,
    |raw.serial_port_request[0],      // 28 R2
    raw.i2c,
    raw.usb_host,
    raw.usb_dev,
    raw.nand_ctl,
    |raw.serial_port_request[1],      // 23 R2
    raw.spi0,
    raw.sd_card,
    raw.dma,                          // 20..17
    |raw.lcd,
    |raw.serial_port_request[2],      // 15 R2
    raw.timer,                        // 14..10
    |raw.wdt_audio,                   // 9 R2
    raw.rtc_tick,
    raw.battery_fault,
    |raw.camera,
    |pins[23:8],                      // 5 R2
    |pins[7:4],                       // 4 R2
    pins[3:0]                         // R1
  };

endmodule // source_gather

// ===== logic/interrupt_request_arbiter.sv
// Purpose: latch, mask, classify and arbitrate interrupt requests
// Assumes: software reaches the registers through sw_write_s strobes
// Notes: fast class skips arbitration and drives its line directly
//
// Summary of operation
// R1: accept sixty requests from peripherals and pins
// R2: OR shared sub-requests onto one source line
// R3: raise fast or normal request after arbitration; the fast line here skips arbitration
// R4: record arbitration winner in winner pending register
// R5: per-source class picks fast or normal line
// R6: requests set source bits; one winner bit
// R7: masked request sets source bit only
// R8: mask one blocks service, zero allows it
// R9: both pending registers readable; write one clears
// R10: software clears source bit before winner bit
// R11: core clears disable flag and mask bit
// R12: group five takes adc, rtc, spi1, uart0
// R13: group four takes six comms sources
// R14: group three takes sd, dma, lcd
// R15: group two takes uart2 and timers
// R16: group one misc, group zero pins 0-3
// R17: input zero first, five last, rest rotate
// R18: rotation sets select from serviced input
// R19: source clear touches only bits written one
// R20: request line holds while unmasked source pending
`timescale 1ns/1ps
module interrupt_request_arbiter
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // requests from peripherals and pins
  input wire irq_pkg::raw_request_s raw,
  // software writes
  input wire irq_pkg::sw_write_s sw,
  // requests to the core
  output logic fiq_request,
  output logic irq_request,
  // register read back
  output logic [31:0] source_pending_reg,
  output logic [31:0] winner_pending_reg,
  output logic [4:0] winner_offset,
  output logic [31:0] source_mask_reg,
  output logic [31:0] source_mode_reg,
  output logic [6:0] rotation_enable,
  output logic [6:0][1:0] priority_select
);

  ////////////////////////////////////////////////////////////////////////
  // source lines and class split

  logic [31:0] source_lines;
  logic [31:0] eligible;
  logic [31:0] fiq_cand;
  logic [31:0] irq_cand;
  logic [35:0] padded;

  source_gather u_gather
  (
    .raw(raw),
    .lines(source_lines)
  );

  assign eligible = source_pending_reg & ~source_mask_reg; // R8
  assign fiq_cand = eligible & source_mode_reg; // R5
  assign irq_cand = eligible & ~source_mode_reg; // R5

  // groups zero and five only use inputs 1..4; the spare slots stay idle
  assign padded = {1'b0, irq_cand[31:28], 1'b0, // R12
                   irq_cand[27:22], // R13
                   irq_cand[21:16], // R14
                   irq_cand[15:10], // R15
                   irq_cand[9:4], // R16
                   1'b0, irq_cand[3:0], 1'b0}; // R16

  ////////////////////////////////////////////////////////////////////////
  // two-level arbitration

  logic [5:0] group_valid;
  logic [5:0][2:0] group_grant;
  logic top_valid;
  logic [2:0] top_grant;

  genvar g;
  generate
    for (g = 0; g < irq_pkg::NUM_GROUPS; g++)
    begin : gen_group
      rotating_arbiter u_arb
      (
        .req(padded[g * irq_pkg::GROUP_WIDTH +: irq_pkg::GROUP_WIDTH]),
        .sel(priority_select[g]),
        .valid(group_valid[g]),
        .grant(group_grant[g])
      );
    end
  endgenerate

  rotating_arbiter u_top
  (
    .req(group_valid),
    .sel(priority_select[irq_pkg::TOP_ARB]),
    .valid(top_valid),
    .grant(top_grant)
  );

  logic [5:0] win_pad_index;
  logic [35:0] win_pad;
  logic [31:0] win_onehot;
  logic [4:0] win_index;
  logic new_win;

  assign win_pad_index = ({3'h0, top_grant} * 6'h06)
                         + {3'h0, group_grant[top_grant]};
  assign win_pad = 36'h1 << win_pad_index;
  // drop the idle slots of groups zero and five
  assign win_onehot = {win_pad[34:31], win_pad[29:6], win_pad[4:1]};
  // a new winner is only marked once the previous one is cleared
  assign new_win = top_valid && (winner_pending_reg == 32'h0); // R6

  always_comb
  begin
    win_index = irq_pkg::OFFSET_RESET;
    for (int i = 0; i < irq_pkg::NUM_LINES; i++)
    begin
      if (win_onehot[i])
      begin
        win_index = 5'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next register values

  logic [31:0] src_clear;
  logic [31:0] win_clear;
  logic [31:0] next_source_pending;
  logic [31:0] next_winner_pending;
  logic [6:0][1:0] next_sel;
  logic [6:0][2:0] served_idx;
  logic [6:0] served;

  assign src_clear = sw.clear_source ? sw.data : 32'h0; // R19
  assign win_clear = sw.clear_winner ? sw.data : 32'h0; // R9
  // set wins over clear so a request arriving with the clear is kept
  assign next_source_pending = (source_pending_reg & ~src_clear)
                               | source_lines; // R6 R7 R9
  assign next_winner_pending = new_win ? win_onehot // R4
                               : (winner_pending_reg & ~win_clear); // R9

  genvar a;
  generate
    for (a = 0; a < irq_pkg::NUM_ARB; a++)
    begin : gen_sel
      if (a == irq_pkg::TOP_ARB)
      begin : gen_top
        assign served_idx[a] = top_grant;
        assign served[a] = new_win;
      end
      else
      begin : gen_first
        assign served_idx[a] = group_grant[a];
        assign served[a] = new_win && (top_grant == 3'(a));
      end
      // rotation wins over a software load in the same cycle
      assign next_sel[a] =
        (served[a] && rotation_enable[a]
         && served_idx[a] >= irq_pkg::REQ_ROT_LO
         && served_idx[a] <= irq_pkg::REQ_ROT_HI) ? served_idx[a][1:0] // R18
        : sw.load_priority
          ? sw.data[irq_pkg::PRIO_SEL_LSB + 2 * a +: irq_pkg::SEL_WIDTH]
          : priority_select[a];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      source_pending_reg <= irq_pkg::PEND_RESET;
      winner_pending_reg <= irq_pkg::PEND_RESET;
      winner_offset <= irq_pkg::OFFSET_RESET;
    end
    else
    begin
      source_pending_reg <= next_source_pending; // R6
      winner_pending_reg <= next_winner_pending; // R4
      if (new_win)
        winner_offset <= win_index; // R4
      else if (next_winner_pending == 32'h0)
        winner_offset <= irq_pkg::OFFSET_RESET;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      source_mask_reg <= irq_pkg::MASK_RESET;
      source_mode_reg <= irq_pkg::MODE_RESET;
      rotation_enable <= irq_pkg::ROT_RESET;
      priority_select <= {irq_pkg::NUM_ARB{irq_pkg::SEL_RESET}};
    end
    else
    begin
      if (sw.load_mask)
        source_mask_reg <= sw.data; // R8
      if (sw.load_mode)
        source_mode_reg <= sw.data; // R5
      if (sw.load_priority)
        rotation_enable <= sw.data[irq_pkg::PRIO_ROT_LSB +: irq_pkg::NUM_ARB];
      priority_select <= next_sel; // R18
    end
  end

  // lines stay up while any unmasked source of the class is pending
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fiq_request <= 1'b0;
      irq_request <= 1'b0;
    end
    else
    begin
      fiq_request <= |fiq_cand; // R3 R20
      irq_request <= |irq_cand; // R3 R20
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  logic past_valid;
  logic [31:0] prev_lines;
  logic [31:0] prev_spnd;
  logic [31:0] prev_clear;
  logic [31:0] prev_mask;
  logic [31:0] prev_winner;
  logic prev_fiq_any;
  logic prev_irq_any;
  logic prev_new_win;
  logic [2:0] prev_top_grant;
  logic prev_top_rot;
  logic prev_load_prio;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      past_valid <= 1'b0;
      prev_lines <= 32'h0;
      prev_spnd <= 32'h0;
      prev_clear <= 32'h0;
      prev_mask <= 32'h0;
      prev_winner <= 32'h0;
      prev_fiq_any <= 1'b0;
      prev_irq_any <= 1'b0;
      prev_new_win <= 1'b0;
      prev_top_grant <= 3'h0;
      prev_top_rot <= 1'b0;
      prev_load_prio <= 1'b0;
    end
    else
    begin
      past_valid <= 1'b1;
      prev_lines <= source_lines;
      prev_spnd <= source_pending_reg;
      prev_clear <= src_clear;
      prev_mask <= source_mask_reg;
      prev_winner <= winner_pending_reg;
      prev_fiq_any <= |fiq_cand;
      prev_irq_any <= |irq_cand;
      prev_new_win <= new_win;
      prev_top_grant <= top_grant;
      prev_top_rot <= rotation_enable[irq_pkg::TOP_ARB];
      prev_load_prio <= sw.load_priority;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence fresh_winner;
    past_valid && prev_new_win;
  endsequence

  source_set_a: assert property ( // R6
    past_valid |-> ((source_pending_reg & prev_lines) == prev_lines))
    else $error("request line did not set its source pending bit");

  source_clear_a: assert property ( // R19
    past_valid |-> ((source_pending_reg & ~prev_clear)
                    == ((prev_spnd | prev_lines) & ~prev_clear)))
    else $error("source clear touched a bit written as zero");

  winner_onehot_a: assert property ( // R6
    $onehot0(winner_pending_reg))
    else $error("more than one winner pending bit set");

  masked_no_win_a: assert property ( // R7
    fresh_winner |-> ((winner_pending_reg & prev_mask) == 32'h0))
    else $error("masked source became the winner");

  winner_hold_a: assert property ( // R4
    (winner_pending_reg != 32'h0) && !sw.clear_winner
    |=> $stable(winner_pending_reg))
    else $error("winner pending changed without a clear");

  fiq_level_a: assert property ( // R20
    past_valid |-> (fiq_request == prev_fiq_any))
    else $error("fast request does not follow pending fast sources");

  irq_level_a: assert property ( // R20
    past_valid && prev_irq_any |-> irq_request ##1 (irq_request
      || !prev_irq_any))
    else $error("normal request dropped while a source pends");

  top_rotate_a: assert property ( // R18
    fresh_winner and (prev_top_rot && prev_top_grant >= irq_pkg::REQ_ROT_LO
    && prev_top_grant <= irq_pkg::REQ_ROT_HI)
    |-> (priority_select[irq_pkg::TOP_ARB] == prev_top_grant[1:0]))
    else $error("second level select did not rotate to serviced input");

  fixed_sel_a: assert property ( // R17
    past_valid && !prev_top_rot && !prev_load_prio
    |-> $stable(priority_select[irq_pkg::TOP_ARB]))
    else $error("select moved with rotation off");

  group_zero_first_a: assert property ( // R17
    new_win && group_valid[0] |=> (winner_offset < 5'h04))
    else $error("group zero lost the second level");

endmodule // interrupt_request_arbiter

// ===== tb/core_request_model.sv
// Purpose: core side model that takes fast and normal requests
// Assumes: requests are levels from the arbiter
// Notes: a taken flag stays set until reset
`timescale 1ns/1ps
module core_request_model
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // requests and disable flags
  input wire logic fiq_request,
  input wire logic irq_request,
  input wire logic fiq_disable,
  input wire logic irq_disable,
  // taken flags
  output logic fiq_taken,
  output logic irq_taken
);
  // a request is only accepted while its disable flag is 0
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fiq_taken <= 1'b0;
      irq_taken <= 1'b0;
    end
    else
    begin
      fiq_taken <= fiq_taken | (fiq_request & ~fiq_disable);
      irq_taken <= irq_taken | (irq_request & ~irq_disable);
    end
  end
endmodule // core_request_model

// ===== tb/interrupt_request_arbiter_bench.sv
// Purpose: self-checking bench for the interrupt request arbiter
// Assumes: inputs change at the falling edge only
// Notes: every drive task waits a falling edge first, so no double drive
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      $display("[ERR] %s exp %0h got %0h", n, e, g); \
      err_count++; \
    end \
  end
module interrupt_request_arbiter_bench;
  localparam logic [4:0] CLR_SRC = 5'h10;
  localparam logic [4:0] CLR_WIN = 5'h08;
  localparam logic [4:0] LD_MASK = 5'h04;
  localparam logic [4:0] LD_MODE = 5'h02;
  localparam logic [4:0] LD_PRIO = 5'h01;
  logic clk;
  logic arst_n;
  irq_pkg::raw_request_s raw;
  irq_pkg::raw_request_s r;
  irq_pkg::sw_write_s sw;
  logic fiq_request;
  logic irq_request;
  logic [31:0] src;
  logic [31:0] win;
  logic [4:0] offs;
  logic [31:0] mask;
  logic [31:0] mode;
  logic [6:0] rot;
  logic [6:0][1:0] sel;
  logic fiq_disable;
  logic irq_disable;
  logic fiq_taken;
  logic irq_taken;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;

  interrupt_request_arbiter i_dut
  (
    .clk(clk),
    .arst_n(arst_n),
    .raw(raw),
    .sw(sw),
    .fiq_request(fiq_request),
    .irq_request(irq_request),
    .source_pending_reg(src),
    .winner_pending_reg(win),
    .winner_offset(offs),
    .source_mask_reg(mask),
    .source_mode_reg(mode),
    .rotation_enable(rot),
    .priority_select(sel)
  );

  core_request_model i_core
  (
    .clk(clk),
    .arst_n(arst_n),
    .fiq_request(fiq_request),
    .irq_request(irq_request),
    .fiq_disable(fiq_disable),
    .irq_disable(irq_disable),
    .fiq_taken(fiq_taken),
    .irq_taken(irq_taken)
  );

  ////////////////////////////////////////////////////////////////////////
  task give_verdict();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task write_sw(input logic [4:0] st, input logic [31:0] d);
    @(negedge clk);
    sw = {st, d};
    @(negedge clk);
    sw = '0;
  endtask

  task pulse(input irq_pkg::raw_request_s p);
    @(negedge clk);
    raw = p;
    @(negedge clk);
    raw = '0;
  endtask

  // service order: source bit first, then the winner bit
  task service(input logic [31:0] d);
    write_sw(CLR_SRC, d);
    write_sw(CLR_WIN, d);
    tick(1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // hang guard; the full run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      give_verdict();
    end
  end

  initial
  begin
    raw = '0;
    r = '0;
    sw = '0;
    fiq_disable = 1'b1;
    irq_disable = 1'b1;
    arst_n = 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    `CHK("src", irq_pkg::PEND_RESET, src)
    `CHK("win", irq_pkg::PEND_RESET, win)
    `CHK("mask", irq_pkg::MASK_RESET, mask)
    `CHK("mode", irq_pkg::MODE_RESET, mode)
    `CHK("rot", irq_pkg::ROT_RESET, rot)
    // masked requests latch but never win
    pulse('1);
    tick(1);
    `CHK("src", 32'hffff_ffff, src)
    `CHK("win", 32'h0000_0000, win)
    `CHK("irq", 1'b0, irq_request)
    write_sw(CLR_SRC, 32'h0000_ff00);
    `CHK("src", 32'hffff_00ff, src)
    pulse('1);
    irq_disable = 1'b0;
    write_sw(LD_MASK, 32'h0000_0000);
    tick(1);
    // fixed priority with all pending gives winners in line order
    for (int i = 0; i < 32; i++)
    begin
      `CHK("win", 32'h1 << i, win)
      `CHK("offs", i[4:0], offs)
      `CHK("irq", 1'b1, irq_request)
      service(32'h1 << i);
    end
    `CHK("win", 32'h0000_0000, win)
    `CHK("offs", 5'h00, offs)
    `CHK("irq", 1'b0, irq_request)
    `CHK("irq_taken", 1'b1, irq_taken)
    // fast class bypasses arbitration
    write_sw(LD_MODE, 32'h0000_0001);
    r.external_pin_request[0] = 1'b1;
    pulse(r);
    tick(1);
    `CHK("fiq", 1'b1, fiq_request)
    `CHK("irq", 1'b0, irq_request)
    `CHK("fiq_taken", 1'b0, fiq_taken)
    fiq_disable = 1'b0;
    tick(1);
    `CHK("fiq_taken", 1'b1, fiq_taken)
    write_sw(CLR_SRC, 32'h0000_0001);
    tick(1);
    `CHK("fiq", 1'b0, fiq_request)
    write_sw(LD_MODE, 32'h0000_0000);
    // rotation on group two only
    write_sw(LD_PRIO, 32'h0000_0004);
    r = '0;
    r.timer[1] = 1'b1;
    pulse(r);
    tick(2);
    `CHK("win", 32'h0000_0800, win)
    `CHK("sel2", 2'h1, sel[2])
    service(32'h0000_0800);
    r.timer[2] = 1'b1;
    pulse(r);
    tick(2);
    `CHK("win", 32'h0000_1000, win)
    `CHK("sel2", 2'h2, sel[2])
    `CHK("sel6", 2'h0, sel[6])
    service(32'h0000_1000);
    `CHK("win", 32'h0000_0800, win)
    service(32'h0000_0800);
    `CHK("win", 32'h0000_0000, win)
    // second level rotation, then a loaded fixed order
    write_sw(LD_PRIO, 32'h0000_0040);
    r = '0;
    r.external_pin_request[4] = 1'b1;
    pulse(r);
    tick(2);
    `CHK("win", 32'h0000_0010, win)
    `CHK("sel6", 2'h1, sel[6])
    `CHK("sel2", 2'h0, sel[2])
    service(32'h0000_0010);
    write_sw(LD_PRIO, 32'h0018_0000);
    `CHK("sel6", 2'h3, sel[6])
    `CHK("rot", 7'h00, rot)
    r.nand_ctl = 1'b1;
    pulse(r);
    tick(2);
    `CHK("win", 32'h0100_0000, win)
    service(32'h0100_0000);
    `CHK("win", 32'h0000_0010, win)
    `CHK("sel6", 2'h3, sel[6])
    service(32'h0000_0010);
    `CHK("win", 32'h0000_0000, win)
    give_verdict();
  end
endmodule // interrupt_request_arbiter_bench
